/* File: sim/uapc_core_tb_top.sv */
// Self-checking bench of the parity UART core.
// Assumes uapc_far as remote partner and divisor 8 (16 clocks per bit).
`timescale 1ns/1ps
`default_nettype none
module uapc_core_tb_top;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [7:0] adr_i = 8'h00;
    logic [31:0] dat_i = 32'h0;
    logic [3:0] sel_i = 4'hF;
    logic [3:0] sel_req = 4'hF;
    logic [31:0] dat_o;
    logic ack_o, sin, sout, txd, rxd, rxe;
    logic [11:0] n_txd = 12'h0;
    logic [11:0] n_rxd = 12'h0;
    logic [11:0] n_rxe = 12'h0;
    int num_errors = 0;
    int checks_done = 0;
    uapc_core #(.DIV_W(8)) u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .serial_in_pin_i(sin), .serial_out_pin_o(sout), .tx_done_irq_o(txd),
        .rx_done_irq_o(rxd), .rx_error_irq_o(rxe));
    uapc_far #(.BT(16)) u_far (.clk_i(clk_i), .line_i(sout), .line_o(sin));
    initial begin
        forever #20 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        n_txd <= n_txd + {11'h0, txd === 1'b1};
        n_rxd <= n_rxd + {11'h0, rxd === 1'b1};
        n_rxe <= n_rxe + {11'h0, rxe === 1'b1};
    end
    task automatic chk(input logic [11:0] g, input logic [11:0] e);
        checks_done++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q);
        int k;
        k = 0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= {24'h0, d};
        sel_i <= sel_req;
        @(posedge clk_i);
        while (ack_o !== 1'b1 && k < 50) begin
            @(posedge clk_i);
            k++;
        end
        chk({11'h0, ack_o}, 12'h1);
        q = dat_o[7:0];
        chk({11'h0, |dat_o[31:8]}, 12'h0);
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        wb(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] q;
        wb(1'b0, a, 8'h00, q);
        chk({4'h0, q}, {4'h0, e});
    endtask
    task automatic t_reset();
        rd(uapc_pkg::ADR_MODE, 8'h01);
        rd(uapc_pkg::ADR_BAUD, 8'hFF);
        rd(uapc_pkg::ADR_RXBUF, 8'hFF);
        rd(uapc_pkg::ADR_RXERR, 8'h00);
        rd(uapc_pkg::ADR_TXSTAT, 8'h00);
        wr(8'h40, 8'h5A);
        rd(8'h40, 8'h00);
        sel_req = 4'hE;
        wr(uapc_pkg::ADR_MODE, 8'h84);
        sel_req = 4'hF;
        rd(uapc_pkg::ADR_MODE, 8'h01);
        $display("reset test done");
    endtask
    task automatic t_rx_off();
        logic [11:0] j;
        wr(uapc_pkg::ADR_BAUD, 8'h08);
        rd(uapc_pkg::ADR_BAUD, 8'h08);
        wr(uapc_pkg::ADR_MODE, 8'h84);
        j = n_rxd;
        u_far.send(12'h1C3, 9);
        rd(uapc_pkg::ADR_RXBUF, 8'hFF);
        chk(n_rxd - j, 12'h0);
        $display("receive enable test done");
    endtask
    task automatic t_parity();
        logic [7:0] d;
        logic pb;
        int n;
        logic [11:0] e, g, j, k;
        d = 8'h07;
        for (int p = 0; p < 4; p++) begin
            pb = (p == 3) ? ^d : (p == 2) ? ~^d : 1'b0;
            n = (p == 0) ? 9 : 10;
            e = (p == 0) ? {3'h0, 1'b1, d} : {2'h0, 1'b1, pb, d};
            wr(uapc_pkg::ADR_MODE, 8'hE4 | {3'h0, p[1:0], 3'h0});
            fork
                u_far.recv(n, g);
                wr(uapc_pkg::ADR_TXBUF, d);
            join
            chk(g, e);
            j = n_rxd;
            k = n_rxe;
            u_far.send((p == 0) ? e : e ^ 12'h100, n);
            rd(uapc_pkg::ADR_RXERR, (p > 1) ? 8'h04 : 8'h00);
            rd(uapc_pkg::ADR_RXBUF, d);
            chk(n_rxe - k, (p > 1) ? 12'h1 : 12'h0);
            chk(n_rxd - j, (p > 1) ? 12'h0 : 12'h1);
        end
        rd(uapc_pkg::ADR_RXERR, 8'h00);
        $display("parity test done");
    endtask
    task automatic t_err();
        logic [11:0] j, k;
        wr(uapc_pkg::ADR_MODE, 8'hE7);
        j = n_rxd;
        k = n_rxe;
        u_far.send(12'h1A5, 9);
        u_far.send(12'h13C, 9);
        rd(uapc_pkg::ADR_RXERR, 8'h01);
        rd(uapc_pkg::ADR_RXBUF, 8'hA5);
        chk(n_rxd - j, 12'h2);
        chk(n_rxe - k, 12'h0);
        u_far.send(12'h25A, 10);
        rd(uapc_pkg::ADR_RXERR, 8'h02);
        rd(uapc_pkg::ADR_RXBUF, 8'h5A);
        j = n_rxd;
        k = n_rxe;
        u_far.pulse(4);
        repeat (40) @(posedge clk_i);
        chk(n_rxd - j + n_rxe - k, 12'h0);
        $display("error test done");
    endtask
    task automatic t_cont();
        logic [11:0] g1, g2, j;
        logic [7:0] q;
        int k;
        wr(uapc_pkg::ADR_MODE, 8'hF2);
        j = n_txd;
        fork
            begin
                u_far.recv(10, g1);
                u_far.recv(10, g2);
            end
            begin
                wr(uapc_pkg::ADR_TXBUF, 8'h36);
                q = 8'h02;
                k = 0;
                while (q[1] !== 1'b0 && k < 20) begin
                    wb(1'b0, uapc_pkg::ADR_TXSTAT, 8'h00, q);
                    k++;
                end
                wr(uapc_pkg::ADR_TXBUF, 8'h81);
                rd(uapc_pkg::ADR_TXSTAT, 8'h03);
            end
        join
        chk(g1, 12'h3B6);
        chk(g2, 12'h301);
        repeat (16) @(posedge clk_i);
        chk(n_txd - j, 12'h2);
        rd(uapc_pkg::ADR_TXSTAT, 8'h00);
        repeat (100) @(posedge clk_i);
        chk({11'h0, sout}, 12'h1);
        chk(n_txd - j, 12'h2);
        j = n_rxd;
        u_far.send(12'h1B6, 9);
        rd(uapc_pkg::ADR_RXERR, 8'h00);
        rd(uapc_pkg::ADR_RXBUF, 8'h36);
        chk(n_rxd - j, 12'h1);
        $display("continuous test done");
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_rx_off();
        t_parity();
        t_err();
        t_cont();
        end_of_test();
    end
    // Whole run needs about 3000 clocks
    initial begin
        repeat (30000) @(posedge clk_i);
        num_errors++;
        end_of_test();
    end
endmodule // uapc_core_tb_top
`default_nettype wire

/* File: sim/uapc_far.sv */
// Remote serial partner: sends frames into the core and captures its output.
// Assumes BT clocks per bit, LSB first, line idling high.
`timescale 1ns/1ps
`default_nettype none
module uapc_far #(
    parameter int BT = 16
) (
    input wire logic clk_i,
    input wire logic line_i,
    output logic line_o
);
    initial line_o = 1'b1;
    // Stop bits come in w, so back-to-back frames never assign twice at once
    task automatic send(input logic [11:0] w, input int n);
        line_o <= 1'b0;
        repeat (BT) @(posedge clk_i);
        for (int i = 0; i < n; i++) begin
            line_o <= w[i];
            repeat (BT) @(posedge clk_i);
        end
    endtask
    // Short low glitch that must not pass as a start bit
    task automatic pulse(input int n);
        line_o <= 1'b0;
        repeat (n) @(posedge clk_i);
        line_o <= 1'b1;
    endtask
    // Samples mid-bit; a frame that never starts reads the idle line after 4000 clocks of waiting
    task automatic recv(input int n, output logic [11:0] r);
        int k;
        k = 0;
        r = 12'h000;
        while (line_i !== 1'b0 && k < 4000) begin
            @(posedge clk_i);
            k++;
        end
        repeat (BT / 2) @(posedge clk_i);
        for (int i = 0; i < n; i++) begin
            repeat (BT) @(posedge clk_i);
            r[i] = line_i;
        end
    endtask
endmodule // uapc_far
`default_nettype wire

/* File: verilog/uapc_baud.sv */
// Bit-time counter of the parity UART core.
// Assumes clr_i and run_i come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module uapc_baud #(
    parameter int W = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic clr_i,
    input wire logic run_i,
    input wire logic [W:0] match_i,
    output logic tick_o
);
    logic [W:0] count;

    assign tick_o = run_i && (count == match_i - 1'b1);

    always_ff @(posedge clk_i) begin
        if (rst_i || clr_i) begin
            count <= '0;
        end else if (tick_o) begin
            count <= '0;
        end else if (run_i) begin
            count <= count + 1'b1;
        end
    end
endmodule // uapc_baud
`default_nettype wire

/* File: verilog/uapc_core.sv */
// Parity UART core: Wishbone register slave, transmitter and receiver.
// Assumes clk_i is the base clock; serial_in_pin_i is asynchronous.
`timescale 1ns/1ps
`default_nettype none
module uapc_core #(
    parameter int DIV_W = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic serial_in_pin_i,
    output logic serial_out_pin_o,
    output logic tx_done_irq_o,
    output logic rx_done_irq_o,
    output logic rx_error_irq_o
);
    generate
        if (DIV_W < 4 || DIV_W > 8) begin : g_bad_width
            $error("DIV_W must lie between 4 and 8");
        end
    endgenerate

    logic [7:0] mode;
    logic [DIV_W-1:0] divisor;
    logic [DIV_W-1:0] div_eff;
    logic power, tx_en, rx_en, merge, char8, stop2;
    logic [1:0] ps;
    logic [3:0] nbits;
    logic [7:0] cmask;
    logic acc, wr, rd;
    logic [7:0] next_rdata;

    assign power = mode[uapc_pkg::MB_POWER];
    assign tx_en = power && mode[uapc_pkg::MB_TXE]; // R7
    assign rx_en = power && mode[uapc_pkg::MB_RXE]; // R17
    assign ps = mode[uapc_pkg::MB_PS_HI:uapc_pkg::MB_PS_LO];
    assign char8 = mode[uapc_pkg::MB_CHAR8];
    assign stop2 = mode[uapc_pkg::MB_STOP2];
    assign merge = mode[uapc_pkg::MB_MERGE];
    assign nbits = char8 ? uapc_pkg::NB_CHAR8 : uapc_pkg::NB_CHAR7; // R2
    assign cmask = char8 ? uapc_pkg::CHAR8_MASK : uapc_pkg::CHAR7_MASK;
    // Divisors below the minimum would squeeze the start-bit check; clamp them
    assign div_eff = (divisor < DIV_W'(uapc_pkg::DIV_MIN)) ? DIV_W'(uapc_pkg::DIV_MIN) : divisor;

    // Bus slave: one wait state, every address answered
    assign acc = cyc_i && stb_i && !ack_o;
    assign wr = acc && we_i && sel_i[0];
    assign rd = acc && !we_i;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= acc;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode <= uapc_pkg::MODE_RESET;
        end else if (wr && adr_i == uapc_pkg::ADR_MODE) begin
            mode <= dat_i[7:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            divisor <= DIV_W'(uapc_pkg::BAUD_RESET);
        end else if (wr && adr_i == uapc_pkg::ADR_BAUD) begin
            divisor <= dat_i[DIV_W-1:0];
        end
    end

    // Transmitter
    uapc_pkg::uapc_state_t tx_state;
    logic [7:0] tx_buf, tx_sh;
    logic [3:0] tx_bits;
    logic buf_full, load_d, tx_par, tx_stop_n, tx_tick, tx_busy;
    logic tx_wr, tx_load, tx_end;

    function automatic logic par_of(input logic [1:0] mode_ps, input logic ones_odd);
        if (mode_ps == uapc_pkg::PS_EVEN) begin
            par_of = ones_odd;
        end else if (mode_ps == uapc_pkg::PS_ODD) begin
            par_of = !ones_odd;
        end else begin
            par_of = 1'b0;
        end
    endfunction

    assign tx_busy = (tx_state != uapc_pkg::ST_IDLE);
    assign tx_wr = wr && adr_i == uapc_pkg::ADR_TXBUF && tx_en; // R7
    assign tx_end = tx_tick && tx_state == uapc_pkg::ST_STOP && (tx_stop_n || !stop2); // R9
    // Guard on load_d: the flag still reads full in the cycle after a load
    assign tx_load = tx_en && buf_full && !load_d && (!tx_busy || tx_end); // R11

    uapc_baud #(.W(DIV_W)) u_tx_baud (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .clr_i(tx_load || !tx_en),
        .run_i(tx_busy),
        .match_i({div_eff, 1'b0}),
        .tick_o(tx_tick)
    );

    always_ff @(posedge clk_i) begin
        if (wr && adr_i == uapc_pkg::ADR_TXBUF) begin
            tx_buf <= dat_i[7:0];
        end
    end

    // Set wins over clear, so a write during the handover is kept
    always_ff @(posedge clk_i) begin
        if (rst_i || !tx_en) begin
            buf_full <= 1'b0;
        end else if (tx_wr) begin
            buf_full <= 1'b1; // R12
        end else if (load_d) begin
            buf_full <= 1'b0; // R13
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            load_d <= 1'b0;
        end else begin
            load_d <= tx_load;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || !tx_en) begin
            tx_state <= uapc_pkg::ST_IDLE;
            tx_sh <= '0;
            tx_bits <= '0;
            tx_par <= 1'b0;
            tx_stop_n <= 1'b0;
        end else if (tx_load) begin
            tx_state <= uapc_pkg::ST_START; // R8
            tx_sh <= tx_buf & cmask;
            tx_par <= par_of(ps, ^(tx_buf & cmask)); // R1 R4 R5
            tx_bits <= '0;
            tx_stop_n <= 1'b0;
        end else if (tx_tick) begin
            case (tx_state)
                uapc_pkg::ST_START: begin
                    tx_state <= uapc_pkg::ST_DATA;
                end
                uapc_pkg::ST_DATA: begin
                    tx_sh <= {1'b0, tx_sh[7:1]};
                    tx_bits <= tx_bits + 4'h1;
                    if (tx_bits == nbits - 4'h1) begin
                        tx_state <= (ps == uapc_pkg::PS_NONE) ? uapc_pkg::ST_STOP
                                                               : uapc_pkg::ST_PAR; // R6
                    end
                end
                uapc_pkg::ST_PAR: begin
                    tx_state <= uapc_pkg::ST_STOP;
                end
                uapc_pkg::ST_STOP: begin
                    if (stop2 && !tx_stop_n) begin
                        tx_stop_n <= 1'b1; // R2
                    end else begin
                        tx_state <= uapc_pkg::ST_IDLE; // R10
                    end
                end
                default: begin
                    tx_state <= uapc_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Line lags the state by one cycle; done lags two, so it meets the stop edge
    logic tx_end_d;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            serial_out_pin_o <= 1'b1;
            tx_end_d <= 1'b0;
            tx_done_irq_o <= 1'b0;
        end else begin
            tx_end_d <= tx_end;
            tx_done_irq_o <= tx_end_d; // R9
            case (tx_state)
                uapc_pkg::ST_START: serial_out_pin_o <= 1'b0;
                uapc_pkg::ST_DATA: serial_out_pin_o <= tx_sh[0];
                uapc_pkg::ST_PAR: serial_out_pin_o <= tx_par;
                default: serial_out_pin_o <= 1'b1; // R25
            endcase
        end
    end

    // Receiver input: three flops, a change counts when the last two agree
    logic rx_s1, rx_s2, rx_s3, rx_f, rx_f_d;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_s1 <= 1'b1;
            rx_s2 <= 1'b1;
            rx_s3 <= 1'b1;
        end else begin
            rx_s1 <= serial_in_pin_i;
            rx_s2 <= rx_s1;
            rx_s3 <= rx_s2;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || !rx_en) begin
            rx_f <= 1'b1; // R17
            rx_f_d <= 1'b1;
        end else begin
            if (rx_s2 == rx_s3) begin
                rx_f <= rx_s3;
            end
            rx_f_d <= rx_f;
        end
    end

    uapc_pkg::uapc_state_t rx_state;
    logic [7:0] rx_sh, rx_buf, next_rxdata;
    logic [3:0] rx_bits;
    logic [2:0] rx_err, new_err;
    logic rx_ones, rx_full, rx_tick, rx_fin, any_err, par_bad, rd_err, rd_buf;

    uapc_baud #(.W(DIV_W)) u_rx_baud (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .clr_i(!rx_en || rx_state == uapc_pkg::ST_IDLE ||
               (rx_state == uapc_pkg::ST_START && rx_tick)),
        .run_i(rx_state != uapc_pkg::ST_IDLE),
        .match_i(rx_state == uapc_pkg::ST_START ? {1'b0, div_eff} : {div_eff, 1'b0}), // R18
        .tick_o(rx_tick)
    );

    assign rx_fin = rx_tick && rx_state == uapc_pkg::ST_STOP; // R21
    assign next_rxdata = char8 ? rx_sh : {1'b0, rx_sh[7:1]};
    assign par_bad = (ps == uapc_pkg::PS_EVEN && rx_ones) ||
                     (ps == uapc_pkg::PS_ODD && !rx_ones); // R3 R5 R6
    always_comb begin
        new_err = '0;
        if (rx_fin) begin
            new_err[uapc_pkg::ES_OVR] = rx_full; // R22
            new_err[uapc_pkg::ES_FRM] = !rx_f;
            new_err[uapc_pkg::ES_PAR] = par_bad;
        end
    end
    assign any_err = |new_err;
    assign rd_err = rd && adr_i == uapc_pkg::ADR_RXERR;
    assign rd_buf = rd && adr_i == uapc_pkg::ADR_RXBUF;

    always_ff @(posedge clk_i) begin
        if (rst_i || !rx_en) begin
            rx_state <= uapc_pkg::ST_IDLE;
            rx_sh <= '0;
            rx_bits <= '0;
            rx_ones <= 1'b0;
        end else begin
            case (rx_state)
                uapc_pkg::ST_IDLE: begin
                    if (rx_f_d && !rx_f) begin
                        rx_state <= uapc_pkg::ST_START; // R18
                    end
                end
                uapc_pkg::ST_START: begin
                    if (rx_tick) begin
                        rx_state <= rx_f ? uapc_pkg::ST_IDLE : uapc_pkg::ST_DATA; // R18
                        rx_bits <= '0;
                        rx_ones <= 1'b0;
                    end
                end
                uapc_pkg::ST_DATA: begin
                    if (rx_tick) begin
                        rx_sh <= {rx_f, rx_sh[7:1]};
                        rx_ones <= rx_ones ^ rx_f;
                        rx_bits <= rx_bits + 4'h1;
                        if (rx_bits == nbits - 4'h1) begin
                            rx_state <= (ps == uapc_pkg::PS_NONE) ? uapc_pkg::ST_STOP
                                                                   : uapc_pkg::ST_PAR; // R6
                        end
                    end
                end
                uapc_pkg::ST_PAR: begin
                    if (rx_tick) begin
                        rx_ones <= rx_ones ^ rx_f; // R3
                        rx_state <= uapc_pkg::ST_STOP; // R20
                    end
                end
                uapc_pkg::ST_STOP: begin
                    if (rx_tick) begin
                        rx_state <= uapc_pkg::ST_IDLE; // R21
                    end
                end
                default: begin
                    rx_state <= uapc_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Overrun keeps the unread byte: no copy while the buffer is full
    always_ff @(posedge clk_i) begin
        if (rst_i || !power) begin
            rx_buf <= uapc_pkg::RXBUF_RESET;
        end else if (rx_fin && !rx_full) begin
            rx_buf <= next_rxdata; // R19
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || !power) begin
            rx_full <= 1'b0;
        end else if (rx_fin) begin
            rx_full <= 1'b1;
        end else if (rd_buf) begin
            rx_full <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || !power) begin
            rx_err <= '0;
        end else begin
            rx_err <= (rd_err ? 3'h0 : rx_err) | new_err; // R23
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_done_irq_o <= 1'b0;
            rx_error_irq_o <= 1'b0;
        end else begin
            rx_done_irq_o <= rx_fin && (!any_err || merge); // R19 R24
            rx_error_irq_o <= rx_fin && any_err && !merge; // R24
        end
    end

    always_comb begin
        next_rdata = '0;
        if (adr_i == uapc_pkg::ADR_MODE) begin
            next_rdata = mode;
        end else if (adr_i == uapc_pkg::ADR_BAUD) begin
            next_rdata = 8'(divisor);
        end else if (adr_i == uapc_pkg::ADR_RXBUF) begin
            next_rdata = rx_buf;
        end else if (adr_i == uapc_pkg::ADR_RXERR) begin
            next_rdata = {5'h00, rx_err};
        end else if (adr_i == uapc_pkg::ADR_TXSTAT) begin
            next_rdata[uapc_pkg::TS_FULL] = buf_full; // R12
            next_rdata[uapc_pkg::TS_BUSY] = tx_busy;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= '0;
        end else if (rd) begin
            dat_o <= {24'h000000, next_rdata};
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_load_alone;
        tx_load && !tx_wr;
    endsequence
    sequence s_both_set;
        buf_full && tx_busy;
    endsequence
    property p_flag_walk;
        s_load_alone |=> s_both_set ##1 (tx_busy && (!buf_full || $past(tx_wr)));
    endproperty
    a_flag_walk: assert property (p_flag_walk) else $error("flag walk broken"); // R13
    property p_idle_mark;
        tx_state == uapc_pkg::ST_IDLE |=> serial_out_pin_o;
    endproperty
    a_idle_mark: assert property (p_idle_mark) else $error("idle line not high"); // R25
    property p_even_tx;
        tx_load && ps == uapc_pkg::PS_EVEN |=> !(^{tx_par, tx_sh});
    endproperty
    a_even_tx: assert property (p_even_tx) else $error("even parity wrong"); // R1
    property p_odd_tx;
        tx_load && ps == uapc_pkg::PS_ODD |=> ^{tx_par, tx_sh};
    endproperty
    a_odd_tx: assert property (p_odd_tx) else $error("odd parity wrong"); // R4
    property p_zero_tx;
        tx_state == uapc_pkg::ST_PAR && ps == uapc_pkg::PS_ZERO |=> !serial_out_pin_o;
    endproperty
    a_zero_tx: assert property (p_zero_tx) else $error("zero parity not low"); // R5
    property p_none_tx;
        tx_state == uapc_pkg::ST_DATA && ps == uapc_pkg::PS_NONE |=> tx_state != uapc_pkg::ST_PAR;
    endproperty
    a_none_tx: assert property (p_none_tx) else $error("parity bit in no-parity"); // R6
    property p_done;
        tx_done_irq_o |-> $past(tx_state, 2) == uapc_pkg::ST_STOP && $past(tx_tick, 2);
    endproperty
    a_done: assert property (p_done) else $error("done pulse off stop end"); // R9
    property p_stay_idle;
        !tx_busy && !buf_full |=> !tx_busy;
    endproperty
    a_stay_idle: assert property (p_stay_idle) else $error("sent with no data"); // R10
    property p_err_clear;
        rd_err && !rx_fin |=> rx_err == 3'h0;
    endproperty
    a_err_clear: assert property (p_err_clear) else $error("error flags not cleared"); // R23
    property p_overrun;
        rx_fin && rx_full |=> $stable(rx_buf) && rx_err[uapc_pkg::ES_OVR];
    endproperty
    a_overrun: assert property (p_overrun) else $error("overrun handled wrong"); // R19
    property p_err_irq;
        rx_fin && any_err && !merge |=> rx_error_irq_o && !rx_done_irq_o;
    endproperty
    a_err_irq: assert property (p_err_irq) else $error("error irq routing wrong"); // R24
    property p_false_start;
        rx_state == uapc_pkg::ST_START && rx_tick && rx_f |=> rx_state == uapc_pkg::ST_IDLE;
    endproperty
    a_false_start: assert property (p_false_start) else $error("high start accepted"); // R18
endmodule // uapc_core
`default_nettype wire

/* File: verilog/uapc_pkg.sv */
// Constants, register map and types of the parity UART core.
// Assumes a classic Wishbone slave with 32-bit data and byte addresses.
// Overview of operation
// (R1) Even parity: parity bit is one when the data has odd ones.
// (R2) Frame: start, 7 or 8 data bits, optional parity, 1 or 2 stops.
// (R3) Receiver flags parity error on odd total in even, even total in odd.
// (R4) Odd parity: parity bit is zero when data has odd ones, else one.
// (R5) Zero parity sends a zero parity bit; receiver never flags it.
// (R6) No parity: no parity bit sent or expected, no parity error.
// (R7) Transmit needs power then transmit enable; each buffer write sends a frame.
// (R8) Frame start moves buffer into shift register; framing bits added.
// (R9) Transmit done pulse when the last stop bit has finished.
// (R10) After a frame the transmitter idles until new buffer data.
// (R11) Buffer takes the next byte once shifting of the current frame began.
// (R12) Status bit 1 is buffer full, bit 0 is shift busy.
// (R13) Flag pair walks 10, 11, 01 during continuous sending.
// (R14) Software writes the next byte only while buffer full reads zero.
// (R15) Software waits for done pulse and idle shifter before reinitialising.
// (R16) On LIN, software waits for whole status zero before each write.
// (R17) Reception and input sampling need power then receive enable.
// (R18) Falling edge starts counter; low at divisor count is a start bit.
// (R19) At stop bit: done pulse, shift copied to buffer unless overrun.
// (R20) Parity error does not abort; error pulse comes at frame end.
// (R21) Receiver checks exactly one stop bit, ignoring a second one.
// (R22) Errors: parity mismatch, missing stop bit, overrun of unread buffer.
// (R23) Reading the error status register clears all its flags.
// (R24) Errors at frame end pulse error irq; merge select picks which line.
// (R25) Idle transmitter holds the output line high.
// (R26) Software reads error status before the receive buffer after an error.
`default_nettype none
package uapc_pkg;
    localparam logic [7:0] ADR_MODE = 8'h00;
    localparam logic [7:0] ADR_BAUD = 8'h04;
    localparam logic [7:0] ADR_TXBUF = 8'h08;
    localparam logic [7:0] ADR_RXBUF = 8'h0C;
    localparam logic [7:0] ADR_RXERR = 8'h10;
    localparam logic [7:0] ADR_TXSTAT = 8'h14;

    localparam logic [7:0] MODE_RESET = 8'h01;
    localparam logic [7:0] BAUD_RESET = 8'hFF;
    localparam logic [7:0] RXBUF_RESET = 8'hFF;
    localparam logic [7:0] DIV_MIN = 8'h08;

    localparam int MB_POWER = 7;
    localparam int MB_TXE = 6;
    localparam int MB_RXE = 5;
    localparam int MB_PS_HI = 4;
    localparam int MB_PS_LO = 3;
    localparam int MB_CHAR8 = 2;
    localparam int MB_STOP2 = 1;
    localparam int MB_MERGE = 0;

    localparam logic [1:0] PS_NONE = 2'h0;
    localparam logic [1:0] PS_ZERO = 2'h1;
    localparam logic [1:0] PS_ODD = 2'h2;
    localparam logic [1:0] PS_EVEN = 2'h3;

    localparam int ES_OVR = 0;
    localparam int ES_FRM = 1;
    localparam int ES_PAR = 2;
    localparam int TS_BUSY = 0;
    localparam int TS_FULL = 1;

    localparam logic [3:0] NB_CHAR7 = 4'h7;
    localparam logic [3:0] NB_CHAR8 = 4'h8;
    localparam logic [7:0] CHAR7_MASK = 8'h7F;
    localparam logic [7:0] CHAR8_MASK = 8'hFF;

    typedef enum logic [2:0] {ST_IDLE, ST_START, ST_DATA, ST_PAR, ST_STOP} uapc_state_t;
endpackage
`default_nettype wire
